// ### cycle_seq_defs.svh
// offsets, field positions, reset values and timing counts of the cycle sequencer
`ifndef CYCLE_SEQ_DEFS_SVH
`define CYCLE_SEQ_DEFS_SVH

`define STATES_PER_CYCLE   6
`define OSC_PER_STATE      2
`define OSC_PER_CYCLE      12
`define PROG_BUS_OSC       6
`define MIN_RESET_OSC      24
`define RESET_HOLD_CYCLES  2'h2
`define SEQ_FIRST_STATE    6'h01

`define PWR_CTRL_OFS       12'h000
`define WAKE_CFG_OFS       12'h004
`define SEQ_STAT_OFS       12'h008

`define IDLE_BIT           0
`define PDOWN_BIT          1
`define PWR_CTRL_RST       2'h0
`define WAKE_CFG_RST       5'h00

`endif

// ### cycle_seq_pkg.sv
// types shared by the cycle sequencer files
package cycle_seq_pkg;

    typedef enum logic [2:0] {
        MODE_RUN   = 3'b001,
        MODE_IDLE  = 3'b010,
        MODE_PDOWN = 3'b100
    } mode_t;

    typedef struct packed {
        logic [5:0] state;
        logic       phase2;
    } seq_t;

    typedef struct packed {
        logic [1:0] trig_sel;
        logic       global_interrupt_enable;
        logic [1:0] int_en;
    } wake_cfg_t;

endpackage : cycle_seq_pkg

// ### sync2.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input  logic             pclk,
    input  logic             presetn,
    input  logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out_reg
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg     <= '0;
            sync_out_reg <= '0;
        end else begin
            meta_reg     <= async_in;
            sync_out_reg <= meta_reg;
        end
    end
endmodule : sync2

// ### state_phase_gen.sv
// six-state, two-phase machine cycle generator
`timescale 1ns/1ps
`include "cycle_seq_defs.svh"
module state_phase_gen
    import cycle_seq_pkg::*;
(
    input  logic pclk,
    input  logic presetn,
    input  logic run,
    input  logic restart,
    output seq_t seq_reg
);
    seq_t seq_next;
    wire  [5:0] rot_state = {seq_reg.state[4:0], seq_reg.state[5]};

    // each phase is one oscillator period, state moves after phase 2
    always_comb begin
        seq_next = seq_reg;
        if (restart) begin
            seq_next.state  = `SEQ_FIRST_STATE;
            seq_next.phase2 = 1'b0;
        end else if (run) begin
            seq_next.phase2 = !seq_reg.phase2;
            if (seq_reg.phase2) begin
                seq_next.state = rot_state;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_reg <= '{state: `SEQ_FIRST_STATE, phase2: 1'b0};
        end else begin
            seq_reg <= seq_next;
        end
    end

    chk_state_onehot : assert property (@(posedge pclk) disable iff (!presetn)
        $onehot(seq_reg.state))
        else $error("sequencer state not one-hot");

    chk_cycle_wrap : assert property (@(posedge pclk) disable iff (!presetn)
        (seq_reg.state[5] && seq_reg.phase2 && run && !restart)
        |=> (seq_reg.state[0] && !seq_reg.phase2)
        ##1 (seq_reg.state[0] || !$past(run) || $past(restart)))
        else $error("machine cycle did not wrap to first state");

    chk_phase_split : assert property (@(posedge pclk) disable iff (!presetn)
        (!seq_reg.phase2 && run && !restart) |=> ($stable(seq_reg.state) && seq_reg.phase2))
        else $error("state changed without second phase");
endmodule : state_phase_gen

// ### cycle_sequencer_power_modes.sv
// machine-cycle sequencer, fetch scheduling and power modes with apb registers
`timescale 1ns/1ps
`include "cycle_seq_defs.svh"
module cycle_sequencer_power_modes
    import cycle_seq_pkg::*;
(
    input  logic        pclk,
    input  logic        presetn,
    input  logic [11:0] paddr,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata_reg,
    output logic        pready_reg,
    output logic        pslverr_reg,
    input  logic        rst_pin,
    input  logic [1:0]  ext_int_n,
    input  logic        ext_program_select,
    input  logic        watchdog_reset,
    input  logic        irq_pending,
    input  logic        external_data_move,
    input  logic        next_byte_needed,
    output seq_t        seq_state,
    output logic        fetch_pulse_reg,
    output logic        opcode_latch_reg,
    output logic        pc_advance_reg,
    output logic        cycle_done_reg,
    output logic        program_store_strobe_n_reg,
    output logic        data_access_reg,
    output logic        cpu_clk_en_reg,
    output logic        periph_clk_en_reg,
    output logic        core_reset_reg,
    output logic [1:0]  ext_int_req_reg,
    output logic [1:0]  wake_req_reg
);
    localparam int DATA_BUS_OSC = 2 * `PROG_BUS_OSC;

    function automatic logic at_slot(input seq_t s, input int idx, input logic ph);
        return s.state[idx] && (s.phase2 == ph);
    endfunction : at_slot

    mode_t       mode_reg;
    mode_t       mode_next;
    logic [1:0]  power_control_reg;
    logic [1:0]  pwr_next;
    wake_cfg_t   wake_cfg_reg;
    wake_cfg_t   cfg_next;
    logic [1:0]  hold_reg;
    logic [1:0]  hold_next;
    logic [1:0]  int_smp_reg;
    logic [1:0]  int_req_next;
    logic [31:0] rdata_mux;
    logic [3:0]  da_len_reg;

    // pin levels cross into the oscillator domain first
    wire  [3:0]  pins_sync;
    sync2 #(
        .WIDTH        (4)
    ) u_pin_sync (
        .pclk         (pclk),
        .presetn      (presetn),
        .async_in     ({ext_program_select, ext_int_n, rst_pin}),
        .sync_out_reg (pins_sync)
    );
    wire         rst_sync     = pins_sync[0];
    wire  [1:0]  int_n_sync   = pins_sync[2:1];
    wire         ext_prog     = pins_sync[3];

    wire         in_run       = (mode_reg == MODE_RUN);
    wire         in_idle      = (mode_reg == MODE_IDLE);
    wire         in_pdown     = (mode_reg == MODE_PDOWN);
    wire         pd_exit      = in_pdown && (mode_next == MODE_RUN);

    // sequencer frozen in power-down, restarted at the first state on wake
    state_phase_gen u_seq (
        .pclk         (pclk),
        .presetn      (presetn),
        .run          (!in_pdown),
        .restart      (pd_exit),
        .seq_reg      (seq_state)
    );

    wire         s1p1         = at_slot(seq_state, 0, 1'b0);
    wire         s4p1         = at_slot(seq_state, 3, 1'b0);
    wire         fifth_state_second_phase = at_slot(seq_state, 4, 1'b1);
    wire         s6p2         = at_slot(seq_state, 5, 1'b1);
    wire         prog_win     = |{seq_state.state[4:3], seq_state.state[1:0]};

    wire         cpu_run      = in_run && !core_reset_reg;
    wire         fetch_ok     = cpu_run && !data_access_reg;
    wire         enter_point  = s6p2 && cpu_run;
    wire         resetting    = (hold_next != 2'h0);

    // apb decode; zero-wait answer one cycle after setup
    wire         apb_setup    = psel && !penable;
    wire         apb_done     = psel && penable && pready_reg;
    wire         hit_pwr      = (paddr == `PWR_CTRL_OFS);
    wire         hit_cfg      = (paddr == `WAKE_CFG_OFS);
    wire         hit_stat     = (paddr == `SEQ_STAT_OFS);
    wire         mapped       = hit_pwr || hit_cfg || hit_stat;
    wire         pwr_wr       = apb_done && pwrite && hit_pwr;
    wire         cfg_wr       = apb_done && pwrite && hit_cfg;

    // wake conditions
    wire         wd_reset     = watchdog_reset && !in_pdown;
    wire         pin_reset    = fifth_state_second_phase && rst_sync;
    wire         pd_wake_rst  = in_pdown && rst_sync;
    wire  [1:0]  pd_wake_int  = {2{in_pdown && wake_cfg_reg.global_interrupt_enable}}
                                & wake_cfg_reg.int_en & ~wake_cfg_reg.trig_sel & ~int_n_sync;
    wire         idle_wake    = in_idle && irq_pending;

    always_comb begin
        rdata_mux = 32'h0;
        if (hit_pwr) begin
            rdata_mux = {30'h0, power_control_reg};
        end else if (hit_cfg) begin
            rdata_mux = {27'h0, wake_cfg_reg};
        end else if (hit_stat) begin
            rdata_mux = {18'h0, ext_int_req_reg, data_access_reg, core_reset_reg, seq_state, mode_reg};
        end
    end

    // internal reset held two machine cycles after the pin is last seen high
    always_comb begin
        hold_next = hold_reg;
        if (wd_reset || pin_reset || pd_wake_rst) begin
            hold_next = `RESET_HOLD_CYCLES;
        end else if (fifth_state_second_phase && hold_reg != 2'h0) begin
            hold_next = hold_reg - 2'h1;
        end
    end

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_RUN: begin
                if (resetting) begin
                    mode_next = MODE_RUN;
                end else if (enter_point && power_control_reg[`PDOWN_BIT]) begin
                    mode_next = MODE_PDOWN;
                end else if (enter_point && power_control_reg[`IDLE_BIT]) begin
                    mode_next = MODE_IDLE;
                end
            end
            MODE_IDLE: begin
                if (resetting || idle_wake) begin
                    mode_next = MODE_RUN;
                end
            end
            MODE_PDOWN: begin
                // no reset on interrupt wake, so the core resumes where it stopped
                if (pd_wake_rst || (|pd_wake_int)) begin
                    mode_next = MODE_RUN;
                end
            end
            default: begin
                mode_next = MODE_RUN;
            end
        endcase
    end

    // a software write in the same cycle as an idle-wake or power-down-exit clear wins; internal reset wins over the write
    always_comb begin
        pwr_next = power_control_reg;
        if (resetting) begin
            pwr_next = `PWR_CTRL_RST;
        end else begin
            if (idle_wake) begin
                pwr_next[`IDLE_BIT] = 1'b0;
            end
            if (pd_exit) begin
                pwr_next = `PWR_CTRL_RST; // idle request dropped too, else the core falls into idle
            end
            if (pwr_wr) begin
                pwr_next = pwdata[1:0];
            end
        end
    end

    assign cfg_next = resetting ? wake_cfg_t'(`WAKE_CFG_RST) : cfg_wr ? wake_cfg_t'(pwdata[4:0]) : wake_cfg_reg;

    // edge mode looks for high then low on successive machine-cycle samples
    assign int_req_next = (wake_cfg_reg.trig_sel & int_smp_reg & ~int_n_sync)
                          | (~wake_cfg_reg.trig_sel & ~int_n_sync);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg          <= MODE_RUN;
            power_control_reg <= `PWR_CTRL_RST;
            wake_cfg_reg      <= wake_cfg_t'(`WAKE_CFG_RST);
            hold_reg          <= 2'h0;
            core_reset_reg    <= 1'b0;
        end else begin
            mode_reg          <= mode_next;
            power_control_reg <= pwr_next;
            wake_cfg_reg      <= cfg_next;
            hold_reg          <= hold_next;
            core_reset_reg    <= resetting;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_en_reg    <= 1'b1;
            periph_clk_en_reg <= 1'b1;
            wake_req_reg      <= 2'h0;
        end else begin
            cpu_clk_en_reg    <= (mode_next == MODE_RUN);
            periph_clk_en_reg <= (mode_next != MODE_PDOWN);
            wake_req_reg      <= pd_wake_int;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_smp_reg     <= 2'h3;
            ext_int_req_reg <= 2'h0;
        end else if (fifth_state_second_phase) begin
            int_smp_reg     <= int_n_sync;
            ext_int_req_reg <= int_req_next;
        end
    end

    // fetch timing ignores where program memory lives; only the strobe depends on it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_pulse_reg            <= 1'b0;
            opcode_latch_reg           <= 1'b0;
            pc_advance_reg             <= 1'b0;
            cycle_done_reg             <= 1'b0;
            program_store_strobe_n_reg <= 1'b1;
        end else begin
            fetch_pulse_reg            <= fetch_ok && (s1p1 || s4p1);
            opcode_latch_reg           <= fetch_ok && s1p1;
            pc_advance_reg             <= fetch_ok && (s1p1 || (s4p1 && next_byte_needed));
            cycle_done_reg             <= cpu_run && s6p2;
            program_store_strobe_n_reg <= !(ext_prog && fetch_ok && prog_win);
        end
    end

    // data access owns the bus for the whole second machine cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_access_reg <= 1'b0;
            da_len_reg      <= 4'h0;
        end else begin
            if (resetting) begin
                data_access_reg <= 1'b0;
            end else if (s6p2) begin
                data_access_reg <= cpu_run && external_data_move && !data_access_reg;
            end
            da_len_reg <= data_access_reg ? da_len_reg + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= apb_setup;
            pslverr_reg <= apb_setup && !mapped;
            prdata_reg  <= apb_setup ? rdata_mux : prdata_reg;
        end
    end

    chk_second_fetch : assert property (@(posedge pclk) disable iff (!presetn)
        (s4p1 && fetch_ok) |=> (fetch_pulse_reg && (pc_advance_reg == $past(next_byte_needed))))
        else $error("second fetch or counter advance wrong");

    chk_opcode_first : assert property (@(posedge pclk) disable iff (!presetn)
        (s1p1 && fetch_ok) |=> (opcode_latch_reg && fetch_pulse_reg) ##1 !opcode_latch_reg)
        else $error("opcode latch not a first-state pulse");

    chk_external_data_move_nofetch : assert property (@(posedge pclk) disable iff (!presetn)
        data_access_reg |=> !opcode_latch_reg && !(fetch_pulse_reg && $past(s4p1)))
        else $error("fetch during data access cycle");

    chk_strobe_skip : assert property (@(posedge pclk) disable iff (!presetn)
        data_access_reg |-> program_store_strobe_n_reg)
        else $error("program strobe during data access");

    chk_data_bus_len : assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(data_access_reg) && !core_reset_reg) |-> (da_len_reg == 4'(DATA_BUS_OSC)))
        else $error("data bus cycle not twice a program bus cycle");

    chk_enter_powerdown : assert property (@(posedge pclk) disable iff (!presetn)
        (enter_point && !resetting && power_control_reg[`PDOWN_BIT]) |=> in_pdown && !periph_clk_en_reg)
        else $error("power-down not entered at cycle end");

    chk_enter_idle : assert property (@(posedge pclk) disable iff (!presetn)
        (enter_point && !resetting && power_control_reg == 2'h1) |=> in_idle && !cpu_clk_en_reg
        && periph_clk_en_reg)
        else $error("idle not entered at cycle end");

    chk_idle_wake : assert property (@(posedge pclk) disable iff (!presetn)
        (in_idle && irq_pending && !pwr_wr) |=> in_run && !power_control_reg[`IDLE_BIT] && cpu_clk_en_reg)
        else $error("interrupt did not end idle");

    chk_pd_frozen : assert property (@(posedge pclk) disable iff (!presetn)
        (in_pdown && !rst_sync && pd_wake_int == 2'h0) |=> in_pdown && $stable(seq_state) && !core_reset_reg)
        else $error("power-down left without wake source");

    chk_pd_reset_wake : assert property (@(posedge pclk) disable iff (!presetn)
        (in_pdown && rst_sync) |=> in_run && core_reset_reg && seq_state.state[0])
        else $error("reset pin did not end power-down");

    chk_reset_sample : assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(core_reset_reg) && !$past(watchdog_reset) && !$past(in_pdown)) |-> $past(fifth_state_second_phase))
        else $error("reset applied outside sample slot");
endmodule : cycle_sequencer_power_modes

// ### ext_mem_model.sv
// behavioural model of external program memory on the multiplexed bus
`timescale 1ns/1ps
module ext_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        strobe_n,
    input  wire logic        data_access,
    output logic [7:0]       code_bus,
    output logic [15:0]      read_count
);
    logic last_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_n     <= 1'b1;
            read_count <= 16'h0000;
            code_bus   <= 8'h00;
        end else begin
            last_n <= strobe_n;
            // one code read ends at each release of the strobe
            if (strobe_n && !last_n)
                read_count <= read_count + 16'h0001;
            if (!strobe_n)
                code_bus <= read_count[7:0] ^ 8'h5a;
            else if (data_access)
                code_bus <= 8'h3c;
            else
                code_bus <= ~code_bus; // released bus toggles so a stale byte never looks valid
        end
    end
endmodule : ext_mem_model

// ### cycle_sequencer_power_modes_test.sv
// self-checking bench for the cycle sequencer and power modes
`timescale 1ns/1ps
`include "cycle_seq_defs.svh"
module cycle_sequencer_power_modes_test;
    typedef struct packed {
        logic [2:0] sel;
        logic [7:0] len, nf, np, ns, nd;
    } row_t;
    logic                pclk, presetn, psel, penable, pwrite, pready_reg, pslverr_reg, err;
    logic                rst_pin, ext_program_select, watchdog_reset, irq_pending;
    logic                external_data_move, next_byte_needed, fetch_pulse_reg, opcode_latch_reg;
    logic                pc_advance_reg, cycle_done_reg, program_store_strobe_n_reg, data_access_reg;
    logic                cpu_clk_en_reg, periph_clk_en_reg, core_reset_reg;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata_reg, rd;
    logic [1:0]          ext_int_n, ext_int_req_reg, wake_req_reg;
    logic [15:0]         read_count, s0;
    cycle_seq_pkg::seq_t seq_state;
    int                  err_total, tests_run, n, nf, np, nd, nc, r;
    // {ext prog, next byte, data move}, cycle length, fetches, pc steps, strobes, data cycles
    row_t rows [5] = '{
        {3'b000, 8'h0c, 8'h02, 8'h01, 8'h00, 8'h00},
        {3'b010, 8'h0c, 8'h02, 8'h02, 8'h00, 8'h00},
        {3'b100, 8'h0c, 8'h02, 8'h01, 8'h02, 8'h00},
        {3'b111, 8'h18, 8'h02, 8'h02, 8'h02, 8'h0c},
        {3'b001, 8'h18, 8'h02, 8'h01, 8'h00, 8'h0c}
    };

    cycle_sequencer_power_modes cycle_sequencer_power_modes_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata_reg(prdata_reg), .pready_reg(pready_reg),
        .pslverr_reg(pslverr_reg), .rst_pin(rst_pin), .ext_int_n(ext_int_n),
        .ext_program_select(ext_program_select), .watchdog_reset(watchdog_reset),
        .irq_pending(irq_pending), .external_data_move(external_data_move),
        .next_byte_needed(next_byte_needed), .seq_state(seq_state), .fetch_pulse_reg(fetch_pulse_reg),
        .opcode_latch_reg(opcode_latch_reg), .pc_advance_reg(pc_advance_reg), .cycle_done_reg(cycle_done_reg),
        .program_store_strobe_n_reg(program_store_strobe_n_reg), .data_access_reg(data_access_reg),
        .cpu_clk_en_reg(cpu_clk_en_reg), .periph_clk_en_reg(periph_clk_en_reg),
        .core_reset_reg(core_reset_reg), .ext_int_req_reg(ext_int_req_reg), .wake_req_reg(wake_req_reg)
    );
    ext_mem_model ext_mem_model_inst (
        .pclk(pclk), .presetn(presetn), .strobe_n(program_store_strobe_n_reg),
        .data_access(data_access_reg), .code_bus(), .read_count(read_count)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task close_out;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    function automatic logic sig(input int k);
        case (k)
            0: return cpu_clk_en_reg;
            1: return periph_clk_en_reg;
            2: return core_reset_reg;
            3: return wake_req_reg[0];
            4: return ext_int_req_reg[1];
            default: return opcode_latch_reg;
        endcase
    endfunction : sig

    // every wait is bounded; running out ends the run as a failure
    task wait_for(input int k, input logic v);
        int i;
        for (i = 0; i < 60 && sig(k) !== v; i++)
            @(posedge pclk);
        if (i == 60) begin
            err_total++;
            $display("ERROR t=%0t wait %h expired at %h", $time, k, i);
            close_out();
        end
    endtask : wait_for

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready_reg === 1'b1)
                break;
        end
        if (i == 16) begin
            err_total++;
            $display("ERROR t=%0t apb wait expired at %h", $time, i);
            close_out();
        end
        rd = prdata_reg;
        err = pslverr_reg;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    initial begin
        {psel, penable, pwrite, rst_pin, watchdog_reset, irq_pending} = '0;
        {external_data_move, next_byte_needed, ext_program_select} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_int_n = 2'b11;
        presetn = 1'b0;
        err_total = 0;
        tests_run = 0;
        repeat (20) @(posedge pclk);
        chk(seq_state, 7'h02);
        chk({program_store_strobe_n_reg, data_access_reg, cpu_clk_en_reg, periph_clk_en_reg,
             core_reset_reg, pready_reg, pslverr_reg}, 7'b1011000);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        $display("test reset done");

        for (r = 0; r < 5; r++) begin
            ext_program_select <= rows[r].sel[2];
            next_byte_needed   <= rows[r].sel[1];
            repeat (24) @(posedge pclk);
            wait_for(5, 1'b1);
            chk(seq_state, 7'h03);
            external_data_move <= rows[r].sel[0];
            nf = fetch_pulse_reg;
            np = pc_advance_reg;
            nd = 0;
            nc = 0;
            s0 = read_count;
            for (n = 1; n < 40; n++) begin
                @(posedge pclk);
                if (data_access_reg === 1'b1) begin
                    nd++;
                    external_data_move <= 1'b0;
                end
                if (opcode_latch_reg === 1'b1)
                    break;
                nf += fetch_pulse_reg;
                np += pc_advance_reg;
                nc += cycle_done_reg;
            end
            chk(nc, rows[r].len / 8'h0c);
            chk(n, rows[r].len);
            chk(nf, rows[r].nf);
            chk(np, rows[r].np);
            chk(read_count - s0, rows[r].ns);
            chk(nd, rows[r].nd);
            external_data_move <= 1'b0;
        end
        $display("test sequencing rows done");

        apb(1'b0, `PWR_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `WAKE_CFG_OFS, 32'hffffffff);
        apb(1'b0, `WAKE_CFG_OFS, 32'h0);
        chk(rd, 32'h1f);
        apb(1'b1, `SEQ_STAT_OFS, 32'h0);
        chk(err, 1'b0);
        apb(1'b0, `SEQ_STAT_OFS, 32'h0);
        chk(rd & 32'h7, 32'h1);
        apb(1'b1, 12'h00c, 32'h0);
        chk(err, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        $display("test registers done");

        apb(1'b1, `PWR_CTRL_OFS, 32'h1);
        wait_for(0, 1'b0);
        chk(periph_clk_en_reg, 1'b1);
        apb(1'b0, `SEQ_STAT_OFS, 32'h0);
        chk(rd & 32'h7, 32'h2);
        nf = 0;
        repeat (24) @(posedge pclk) nf += fetch_pulse_reg;
        chk(nf, 0);
        irq_pending <= 1'b1;
        wait_for(0, 1'b1);
        irq_pending <= 1'b0;
        apb(1'b0, `PWR_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        $display("test idle done");

        apb(1'b1, `PWR_CTRL_OFS, 32'h1);
        wait_for(0, 1'b0);
        rst_pin <= 1'b1;
        wait_for(2, 1'b1);
        repeat (30) @(posedge pclk);
        chk(cpu_clk_en_reg, 1'b1);
        rst_pin <= 1'b0;
        wait_for(2, 1'b0);
        apb(1'b0, `WAKE_CFG_OFS, 32'h0);
        chk(rd, 32'h0);
        watchdog_reset <= 1'b1;
        @(posedge pclk);
        watchdog_reset <= 1'b0;
        wait_for(2, 1'b1);
        wait_for(2, 1'b0);
        $display("test reset sources done");

        apb(1'b1, `WAKE_CFG_OFS, 32'h05);
        apb(1'b1, `PWR_CTRL_OFS, 32'h3);
        wait_for(1, 1'b0);
        chk(cpu_clk_en_reg, 1'b0);
        apb(1'b0, `SEQ_STAT_OFS, 32'h0);
        chk(rd & 32'h7, 32'h4);
        watchdog_reset <= 1'b1;
        @(posedge pclk);
        watchdog_reset <= 1'b0;
        repeat (30) @(posedge pclk);
        chk({periph_clk_en_reg, core_reset_reg}, 2'b00);
        ext_int_n <= 2'b10;
        wait_for(3, 1'b1);
        repeat (2) @(posedge pclk);
        chk({cpu_clk_en_reg, periph_clk_en_reg, core_reset_reg}, 3'b110);
        ext_int_n <= 2'b11;
        apb(1'b0, `PWR_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        // edge-triggered pin must not wake, so only the reset pin gets out
        apb(1'b1, `WAKE_CFG_OFS, 32'h0d);
        apb(1'b1, `PWR_CTRL_OFS, 32'h2);
        wait_for(1, 1'b0);
        ext_int_n <= 2'b10;
        repeat (30) @(posedge pclk);
        chk(periph_clk_en_reg, 1'b0);
        rst_pin <= 1'b1;
        wait_for(1, 1'b1);
        wait_for(2, 1'b1);
        repeat (24) @(posedge pclk);
        rst_pin <= 1'b0;
        ext_int_n <= 2'b11;
        wait_for(2, 1'b0);
        $display("test power-down done");

        ext_int_n <= 2'b01;
        wait_for(4, 1'b1);
        repeat (12) @(posedge pclk);
        chk(ext_int_req_reg[1], 1'b1);
        ext_int_n <= 2'b11;
        apb(1'b1, `WAKE_CFG_OFS, 32'h10);
        repeat (30) @(posedge pclk);
        ext_int_n <= 2'b01;
        wait_for(4, 1'b1);
        // pin still low: edge mode must not request again on the next sample
        repeat (12) @(posedge pclk);
        chk(ext_int_req_reg[1], 1'b0);
        ext_int_n <= 2'b11;
        $display("test interrupt trigger done");
        close_out();
    end
endmodule : cycle_sequencer_power_modes_test
